// >>> opsq_defs.sv
// opsq_defs: shared constants and carrier types for the otp program
// sequencer, plus the three-stage pin synchroniser it uses.
// assumes a single 20 MHz clock and a synchronous active-low reset.
`default_nettype none

package opsq_pkg;
   // ------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------
   localparam int ADDR_W      = 17;
   localparam int DATA_W      = 8;
   localparam int CNT_W       = 12;
   localparam int RETRY_W     = 4;
   localparam int CLK_MHZ     = 20;
   localparam int PW_US       = 100;     // nominal program pulse
   localparam int PW_MIN_US   = 95;
   localparam int PW_MAX_US   = 105;
   localparam int SETUP_US    = 2;       // address/data/supply setup+hold
   localparam int OE_VALID_NS = 150;     // output_valid_delay
   localparam int OE_FLOAT_NS = 130;     // output_float_delay
   localparam int SYNC_LAT    = 3;
   localparam int PW_CYC      = PW_US * CLK_MHZ;
   localparam int PW_MIN_CYC  = PW_MIN_US * CLK_MHZ;
   localparam int PW_MAX_CYC  = PW_MAX_US * CLK_MHZ;
   localparam int SETUP_CYC   = SETUP_US * CLK_MHZ;
   localparam int OE_CYC      = (OE_VALID_NS * CLK_MHZ + 999) / 1000;
   localparam int DFP_CYC     = (OE_FLOAT_NS * CLK_MHZ + 999) / 1000;
   // one cycle for the agree stage, one for a pin change on the edge
   localparam int READ_CYC    = OE_CYC + SYNC_LAT + 2;
   localparam int MAX_RETRY   = 10;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 17'h00000;
   localparam logic [ADDR_W-1:0] ADDR_LAST  = 17'h1FFFF;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              data_oe;
      logic              ce_n;
      logic              oe_n;
      logic              pgm_n;
      logic              vcc_prog;   // 1: core supply 6.5V, 0: 5.0V
      logic              vpp_prog;   // 1: programming_supply 13.0V
      logic              id_hv;      // 1: id_high_voltage on select line
   } opsq_pins_t;

   typedef struct packed {
      logic              busy;
      logic              done;
      logic              pass;
      logic              fail;
      logic [ADDR_W-1:0] fail_addr;
      logic [DATA_W-1:0] mfr_code;
      logic [DATA_W-1:0] dev_code;
   } opsq_status_t;
endpackage

// ------------------------------------------------------------
// three-flop synchroniser, output follows once stages 2 and 3 agree
// ------------------------------------------------------------
module opsq_sync3 #(
   parameter int W = 8
) (
   input  wire logic         core_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   wire          agree = (s2_reg == s3_reg);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_out  <= '0;
      end else if (ce_in) begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (agree) begin
            q_out <= s3_reg;
         end
      end
   end
endmodule

`default_nettype wire

// >>> opsq_sequencer.sv
// opsq_sequencer: host controller that programs and checks a one-time
// programmable 128K x 8 eprom through its pins, and reads its id codes.
// assumes external switches turn vcc_prog/vpp_prog/id_hv into voltages.
//
// Operation
// - programming starts with the address at the lowest location.
// - core supply goes to 6.5V and programming supply to 13.0V first.
// - a first pass gives every address one 100us pulse, no verify.
// - after that pass a verify and reprogram loop runs per address.
// - a wrong byte gets up to 10 more pulses, each one read back.
// - a byte still wrong after 10 pulses fails the whole device.
// - a verified byte moves on to the next address until the last.
// - after the loop both supplies drop to 5.0V.
// - at 5.0V every byte is read and compared; pass only if all match. (skipped when the loop has already failed a byte)
// - each program pulse lasts between 95 and 105 microseconds.
// - data is valid 150ns after output enable falls, floats 130ns after.
// - core supply goes up no later and down no earlier than vpp.
// - id reads hold the select line at the 11.5 to 12.5V level.
`default_nettype none

module opsq_sequencer
   import opsq_pkg::*;
#(
   parameter logic [ADDR_W-1:0] LAST_ADDR = ADDR_LAST
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic                   ce_in,
   input  wire logic                   start_in,
   input  wire logic                   id_start_in,
   input  wire logic                   data_ack_in,
   input  wire logic [DATA_W-1:0]      want_data_in,
   input  wire logic [DATA_W-1:0]      data_in,
   output logic                        data_req_out,
   output opsq_pkg::opsq_pins_t        pins_out,
   output opsq_pkg::opsq_status_t      status_out
);
   import opsq_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_VCC_UP, S_VPP_UP, S_FETCH, S_SETUP, S_PULSE, S_HOLD,
      S_OE_ON, S_OE_OFF, S_VPP_DN, S_VCC_DN, S_ID_SET, S_DONE
   } opsq_state_t;

   typedef enum logic [1:0] {
      P_FIRST, P_LOOP, P_FINAL, P_IDENT
   } opsq_phase_t;

   opsq_state_t         state_reg;
   opsq_phase_t         phase_reg;
   logic [CNT_W-1:0]    cnt_reg;
   logic [RETRY_W-1:0]  retry_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [DATA_W-1:0]   want_reg;
   logic                match_reg;
   logic                data_oe_reg;
   logic                oe_n_reg;
   logic                pgm_n_reg;
   logic                vcc_reg;
   logic                vpp_reg;
   logic                id_hv_reg;
   logic                fail_reg;
   logic                pass_reg;
   logic                done_reg;
   logic [ADDR_W-1:0]   fail_addr_reg;
   logic [DATA_W-1:0]   mfr_reg;
   logic [DATA_W-1:0]   dev_reg;
   logic [DATA_W-1:0]   rd_sync;

   function automatic logic hit(input logic [CNT_W-1:0] c, input int n);
      return c == CNT_W'(n - 1);
   endfunction

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire at_last    = (addr_reg == LAST_ADDR);
   wire setup_done = hit(cnt_reg, SETUP_CYC);
   wire pulse_done = hit(cnt_reg, PW_CYC);
   wire read_done  = hit(cnt_reg, READ_CYC);
   wire float_done = hit(cnt_reg, DFP_CYC);
   wire retry_max  = (retry_reg == RETRY_W'(MAX_RETRY));
   wire [ADDR_W-1:0] addr_inc = addr_reg + ADDR_W'(1);
   wire [CNT_W-1:0]  cnt_inc  = cnt_reg + CNT_W'(1);

   assign data_req_out = (state_reg == S_FETCH);

   opsq_sync3 #(
      .W (DATA_W)
   ) u_rd_sync (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .ce_in       (ce_in),
      .d_in        (data_in),
      .q_out       (rd_sync)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_reg     <= S_IDLE;
         phase_reg     <= P_FIRST;
         cnt_reg       <= '0;
         retry_reg     <= '0;
         addr_reg      <= ADDR_FIRST;
         want_reg      <= '0;
         match_reg     <= 1'b0;
         data_oe_reg   <= 1'b0;
         oe_n_reg      <= 1'b1;
         pgm_n_reg     <= 1'b1;
         vcc_reg       <= 1'b0;
         vpp_reg       <= 1'b0;
         id_hv_reg     <= 1'b0;
         fail_reg      <= 1'b0;
         pass_reg      <= 1'b0;
         done_reg      <= 1'b0;
         fail_addr_reg <= '0;
         mfr_reg       <= '0;
         dev_reg       <= '0;
      end else if (ce_in) begin
         cnt_reg  <= cnt_inc;
         done_reg <= 1'b0;
         unique case (state_reg)
            S_IDLE: begin
               cnt_reg <= '0;
               if (start_in) begin
                  addr_reg  <= ADDR_FIRST;
                  phase_reg <= P_FIRST;
                  retry_reg <= '0;
                  fail_reg  <= 1'b0;
                  pass_reg  <= 1'b0;
                  vcc_reg   <= 1'b1;
                  state_reg <= S_VCC_UP;
               end else if (id_start_in) begin
                  addr_reg  <= ADDR_FIRST;
                  phase_reg <= P_IDENT;
                  id_hv_reg <= 1'b1;
                  state_reg <= S_ID_SET;
               end
            end
            S_VCC_UP: begin
               if (setup_done) begin
                  vpp_reg   <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= S_VPP_UP;
               end
            end
            S_VPP_UP: begin
               if (setup_done) begin
                  state_reg <= S_FETCH;
               end
            end
            S_FETCH: begin
               cnt_reg <= '0;
               if (data_ack_in) begin
                  want_reg  <= want_data_in;
                  if (phase_reg == P_FIRST) begin
                     data_oe_reg <= 1'b1;
                     state_reg   <= S_SETUP;
                  end else begin
                     // loop and final visits verify first
                     oe_n_reg  <= 1'b0;
                     state_reg <= S_OE_ON;
                  end
               end
            end
            S_SETUP: begin
               data_oe_reg <= 1'b1;
               if (setup_done) begin
                  pgm_n_reg <= 1'b0;
                  cnt_reg   <= '0;
                  state_reg <= S_PULSE;
               end
            end
            S_PULSE: begin
               // pulse held exactly the nominal width
               if (pulse_done) begin
                  pgm_n_reg <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (setup_done) begin
                  data_oe_reg <= 1'b0;
                  cnt_reg     <= '0;
                  if (phase_reg == P_FIRST) begin
                     // one pulse per address, no verify
                     if (at_last) begin
                        // loop restarts at the first address
                        phase_reg <= P_LOOP;
                        addr_reg  <= ADDR_FIRST;
                     end else begin
                        addr_reg <= addr_inc;
                     end
                     state_reg <= S_FETCH;
                  end else begin
                     oe_n_reg  <= 1'b0;
                     state_reg <= S_OE_ON;
                  end
               end
            end
            S_OE_ON: begin
               // wait out valid delay plus sync latency
               if (read_done) begin
                  match_reg <= (rd_sync == want_reg);
                  if (phase_reg == P_IDENT) begin
                     if (addr_reg[0]) begin
                        dev_reg <= rd_sync;
                     end else begin
                        mfr_reg <= rd_sync;
                     end
                  end
                  oe_n_reg  <= 1'b1;
                  cnt_reg   <= '0;
                  state_reg <= S_OE_OFF;
               end
            end
            S_OE_OFF: begin
               // let the outputs float before driving
               if (float_done) begin
                  cnt_reg <= '0;
                  unique case (phase_reg)
                     P_IDENT: begin
                        if (addr_reg[0]) begin
                           id_hv_reg <= 1'b0;
                           done_reg  <= 1'b1;
                           state_reg <= S_DONE;
                        end else begin
                           addr_reg  <= ADDR_W'(1);
                           oe_n_reg  <= 1'b0;
                           state_reg <= S_OE_ON;
                        end
                     end
                     P_LOOP: begin
                        if (match_reg) begin
                           // count clears on a new address
                           retry_reg <= '0;
                           if (at_last) begin
                              vpp_reg   <= 1'b0;
                              state_reg <= S_VPP_DN;
                           end else begin
                              addr_reg  <= addr_inc;
                              state_reg <= S_FETCH;
                           end
                        end else if (retry_max) begin
                           // ten extra pulses used, device failed
                           fail_reg      <= 1'b1;
                           fail_addr_reg <= addr_reg;
                           vpp_reg       <= 1'b0;
                           state_reg     <= S_VPP_DN;
                        end else begin
                           // one more pulse, then read back
                           retry_reg   <= retry_reg + RETRY_W'(1);
                           data_oe_reg <= 1'b1;
                           state_reg   <= S_SETUP;
                        end
                     end
                     default: begin
                        if (!match_reg && !fail_reg) begin
                           fail_reg      <= 1'b1;
                           fail_addr_reg <= addr_reg;
                        end
                        if (at_last) begin
                           pass_reg  <= fail_reg ? 1'b0 : match_reg;
                           done_reg  <= 1'b1;
                           state_reg <= S_DONE;
                        end else begin
                           addr_reg  <= addr_inc;
                           state_reg <= S_FETCH;
                        end
                     end
                  endcase
               end
            end
            S_VPP_DN: begin
               if (setup_done) begin
                  vcc_reg   <= 1'b0;
                  cnt_reg   <= '0;
                  state_reg <= S_VCC_DN;
               end
            end
            S_VCC_DN: begin
               if (setup_done) begin
                  if (fail_reg) begin
                     done_reg  <= 1'b1;
                     state_reg <= S_DONE;
                  end else begin
                     phase_reg <= P_FINAL;
                     addr_reg  <= ADDR_FIRST;
                     state_reg <= S_FETCH;
                  end
               end
            end
            S_ID_SET: begin
               if (setup_done) begin
                  oe_n_reg  <= 1'b0;
                  cnt_reg   <= '0;
                  state_reg <= S_OE_ON;
               end
            end
            S_DONE: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // chip stays selected for the whole run; a deselect would cost setup
   wire ce_n_w = (state_reg == S_IDLE) || (state_reg == S_DONE);

   assign pins_out = '{addr: addr_reg, data: want_reg,
                       data_oe: data_oe_reg, ce_n: ce_n_w,
                       oe_n: oe_n_reg, pgm_n: pgm_n_reg,
                       vcc_prog: vcc_reg, vpp_prog: vpp_reg,
                       id_hv: id_hv_reg};

   assign status_out = '{busy: !ce_n_w, done: done_reg, pass: pass_reg,
                         fail: fail_reg, fail_addr: fail_addr_reg,
                         mfr_code: mfr_reg, dev_code: dev_reg};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [CNT_W-1:0] pw_len_reg;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pw_len_reg <= '0;
      end else if (ce_in) begin
         pw_len_reg <= pgm_n_reg ? '0 : pw_len_reg + CNT_W'(1);
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_vcc_alone;
      (vcc_reg && !vpp_reg)[*8];
   endsequence

   a_pulse_width: assert property ($rose(pgm_n_reg) |->
      pw_len_reg >= CNT_W'(PW_MIN_CYC) && pw_len_reg <= CNT_W'(PW_MAX_CYC))
      else $error("program pulse width out of range");
   a_supply_order: assert property (vpp_reg |-> vcc_reg)
      else $error("programming supply on without core supply");
   a_vcc_leads: assert property ($rose(vcc_reg) |-> s_vcc_alone)
      else $error("programming supply raised too soon");
   a_pulse_supply: assert property (!pgm_n_reg
      |-> vcc_reg && vpp_reg)
      else $error("pulse without programming supplies");
   a_start_addr: assert property ($rose(vcc_reg) |-> addr_reg == '0)
      else $error("sequence not started at lowest address");
   a_retry_cap: assert property (retry_reg <= RETRY_W'(MAX_RETRY))
      else $error("too many reprogram pulses");
   a_no_contend: assert property (!oe_n_reg |-> !data_oe_reg)
      else $error("data driven while outputs enabled");
   a_float_wait: assert property ($rose(data_oe_reg) |->
      $past(oe_n_reg, 1) && $past(oe_n_reg, 2) && $past(oe_n_reg, 3))
      else $error("data driven before outputs floated");
   a_fail_cause: assert property ($rose(fail_reg)
      && phase_reg == P_LOOP |-> retry_max)
      else $error("failure declared before ten pulses");
   a_retry_clear: assert property ($changed(addr_reg)
      && phase_reg == P_LOOP |-> retry_reg == '0)
      else $error("reprogram count not cleared on new address");
   a_done_low: assert property (done_reg && phase_reg != P_IDENT
      |-> !vcc_reg && !vpp_reg)
      else $error("sequence ended with raised supplies");
   a_pass_clean: assert property (pass_reg |-> !fail_reg)
      else $error("pass and fail both set");
endmodule

`default_nettype wire

// >>> opsq_eprom_model.sv
// opsq_eprom_model: behavioural otp eprom seen from its pins.
// assumes supply bits stand for voltages and three cells are used.
`default_nettype none

module opsq_eprom_model
   import opsq_pkg::*;
#(
   parameter int                NADDR    = 3,
   parameter logic [DATA_W-1:0] MFR_CODE = 8'h5A,  // arbitrary value
   parameter logic [DATA_W-1:0] DEV_CODE = 8'hC3   // arbitrary value
) (
   input  wire opsq_pkg::opsq_pins_t pins_in,
   input  wire logic                 fresh_in,
   input  wire logic [ADDR_W-1:0]    slow_addr_in,
   input  wire logic [7:0]           slow_need_in,
   input  wire logic                 weak_en_in,
   input  wire logic [ADDR_W-1:0]    weak_addr_in,
   output var  logic [DATA_W-1:0]    data_out,
   output var  logic [15:0]          viol_out,
   output var  logic [15:0]          pulses_out,
   output var  logic [15:0]          finals_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // cells and read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [NADDR];
   int                tries [NADDR];
   int                viol = 0;
   int                pulses = 0;
   int                finals = 0;
   logic              drv = 1'b0;
   logic              armed = 1'b0;
   realtime           t_fall;
   logic [ADDR_W-1:0] a;
   logic              in_range;
   logic              flip;
   logic [DATA_W-1:0] val;
   assign a = pins_in.addr;
   assign in_range = (int'(a) < NADDR);
   // a weak cell reads right at 6.5V but reads bit 0 inverted at 5V
   assign flip = weak_en_in && !pins_in.vcc_prog && (a == weak_addr_in);
   // index line picks maker or type code
   assign val = pins_in.id_hv ? (a[0] ? DEV_CODE : MFR_CODE)
              : in_range ? (mem[int'(a)] ^ {7'h00, flip}) : 8'hFF;
   // floating pins show the inverse, so a stale byte never passes
   assign data_out = drv ? val : ~val;
   assign viol_out = 16'(viol);
   assign pulses_out = 16'(pulses);
   assign finals_out = 16'(finals);
   // valid 150ns after enable falls, floats 130ns after it rises
   always @(pins_in.oe_n) begin
      if (pins_in.oe_n)
         #(OE_FLOAT_NS) drv = 1'b0;
      else
         #(OE_VALID_NS) drv = !pins_in.oe_n && !pins_in.ce_n;
   end
   always @(posedge fresh_in) begin
      for (int i = 0; i < NADDR; i++) begin
         mem[i] = 8'hFF;
         tries[i] = 0;
      end
      viol = 0;
      pulses = 0;
      finals = 0;
      armed = 1'b0;
   end
   // ------------------------------------------------------------
   // programming and protocol watch
   // ------------------------------------------------------------
   always @(negedge pins_in.pgm_n) begin
      t_fall = $realtime;
      armed = 1'b1;
      // supplies raised and byte driven before a pulse
      if (!pins_in.vcc_prog || !pins_in.vpp_prog || !pins_in.data_oe)
         viol++;
      // first pass walks up from address zero
      if (pulses < NADDR && int'(a) != pulses)
         viol++;
   end
   always @(posedge pins_in.pgm_n) begin
      if (armed) begin
         // pulse between 95 and 105 us
         if ($realtime - t_fall < 95000.0 || $realtime - t_fall > 105000.0)
            viol++;
         pulses++;
         if (in_range) begin
            tries[int'(a)]++;
            if (tries[int'(a)] >= ((a == slow_addr_in) ? slow_need_in : 1))
               mem[int'(a)] = pins_in.data;
         end
      end
   end
   always @(negedge pins_in.oe_n) begin
      // no verify before every byte had its first pulse
      if (pins_in.vpp_prog && pulses < NADDR)
         viol++;
      // host must not drive while the device is asked to
      if (pins_in.data_oe)
         viol++;
      // id level only with supplies at rest
      if (pins_in.id_hv && (pins_in.vpp_prog || pins_in.vcc_prog))
         viol++;
      // reads at 5V are the final pass
      if (!pins_in.vpp_prog && !pins_in.vcc_prog && !pins_in.id_hv)
         finals++;
   end
   // core supply never below programming supply
   always @(pins_in.vcc_prog or pins_in.vpp_prog) begin
      if (pins_in.vpp_prog && !pins_in.vcc_prog)
         viol++;
   end
endmodule

`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for opsq_sequencer against the eprom model.
// assumes a three byte array via LAST_ADDR; expectations use that size.
`default_nettype none

module tb
   import opsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int                NADDR = 3;
   localparam logic [ADDR_W-1:0] LAST  = 17'h00002;
   localparam logic [DATA_W-1:0] MFR   = 8'h5A;  // arbitrary value
   localparam logic [DATA_W-1:0] DEV   = 8'hC3;  // arbitrary value
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              ce = 1'b1;
   logic              start = 1'b0;
   logic              id_start = 1'b0;
   logic              ack = 1'b0;
   logic              fresh = 1'b0;
   logic              weak_en = 1'b0;
   logic [DATA_W-1:0] want = 8'h00;
   logic [7:0]        need = 8'h01;
   logic [ADDR_W-1:0] slow_a = 17'h00000;
   logic [ADDR_W-1:0] weak_a = 17'h00000;
   logic              req;
   logic [DATA_W-1:0] rd;
   opsq_pins_t        pins;
   opsq_status_t      st;
   logic [15:0]       viol;
   logic [15:0]       pulses;
   logic [15:0]       finals;
   int                n_fail = 0;
   int                num_checks = 0;

   always #25 clk = ~clk;

   opsq_sequencer #(.LAST_ADDR(LAST)) dut (
      .core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .start_in(start),
      .id_start_in(id_start), .data_ack_in(ack), .want_data_in(want),
      .data_in(rd), .data_req_out(req), .pins_out(pins), .status_out(st));
   opsq_eprom_model #(.NADDR(NADDR), .MFR_CODE(MFR), .DEV_CODE(DEV)) u_eprom (
      .pins_in(pins), .fresh_in(fresh), .slow_addr_in(slow_a),
      .slow_need_in(need), .weak_en_in(weak_en), .weak_addr_in(weak_a),
      .data_out(rd), .viol_out(viol), .pulses_out(pulses),
      .finals_out(finals));

   function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
      return 8'h3C + a[7:0];
   endfunction
   // data source answers a request one cycle late, a mild stall
   always @(posedge clk) begin
      ack <= rst_n && req && !ack;
      want <= (rst_n && req) ? pat(pins.addr) : 8'h00;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // starts a run on a fresh part and waits for its done pulse
   task automatic launch(input logic prog, input logic [ADDR_W-1:0] sa,
                         input logic [7:0] sn, input logic [ADDR_W-1:0] wa,
                         input logic we);
      int i;
      @(posedge clk);
      slow_a <= sa;
      need <= sn;
      weak_a <= wa;
      weak_en <= we;
      fresh <= 1'b1;
      start <= prog;
      id_start <= !prog;
      @(posedge clk);
      fresh <= 1'b0;
      start <= 1'b0;
      id_start <= 1'b0;
      for (i = 0; i < 40000; i++) begin
         @(posedge clk);
         #1;
         if (st.done === 1'b1)
            break;
      end
      chk("done", 32'h1, 32'(i < 40000));
   endtask
   task automatic tally(input string name, input int np, input int nf);
      chk("violations", 32'h0, 32'(viol));
      chk("pulses", 32'(np), 32'(pulses));
      chk("final reads", 32'(nf), 32'(finals));
      chk("busy", 32'h0, 32'(st.busy));
      $display("test %s ended", name);
   endtask

   task automatic t_ident;
      launch(1'b0, 17'h00000, 8'h01, 17'h00000, 1'b0);
      tally("ident", 0, 0);
      chk("maker code", 32'(MFR), 32'(st.mfr_code));
      chk("type code", 32'(DEV), 32'(st.dev_code));
   endtask
   // with the clock enable low an id request must not be taken
   task automatic t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      id_start <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk("frozen busy", 32'h0, 32'(st.busy));
      chk("frozen id level", 32'h0, 32'(pins.id_hv));
      @(posedge clk);
      ce <= 1'b1;
      id_start <= 1'b0;
      $display("test freeze ended");
   endtask
   task automatic t_clean;
      launch(1'b1, 17'h00000, 8'h01, 17'h00000, 1'b0);
      tally("clean", NADDR, NADDR);
      chk("pass", 32'h1, 32'(st.pass));
      chk("fail", 32'h0, 32'(st.fail));
      for (int i = 0; i < NADDR; i++)
         chk("cell", 32'(pat(17'(i))), 32'(u_eprom.mem[i]));
   endtask
   task automatic t_weak;
      launch(1'b1, 17'h00000, 8'h02, 17'h00002, 1'b1);
      tally("weak cell", NADDR + 1, NADDR);
      chk("pass", 32'h0, 32'(st.pass));
      chk("fail", 32'h1, 32'(st.fail));
      chk("fail addr", 32'h2, 32'(st.fail_addr));
   endtask
   task automatic t_tenth;
      launch(1'b1, 17'h00001, 8'h0B, 17'h00000, 1'b0);
      tally("ten retries", NADDR + 10, NADDR);
      chk("pass", 32'h1, 32'(st.pass));
   endtask
   task automatic t_dead;
      launch(1'b1, 17'h00001, 8'h0C, 17'h00000, 1'b0);
      tally("dead byte", NADDR + 10, 0);
      chk("pass", 32'h0, 32'(st.pass));
      chk("fail", 32'h1, 32'(st.fail));
      chk("fail addr", 32'h1, 32'(st.fail_addr));
   endtask

   initial begin
      #(95000 * 50);
      n_fail++;
      $display("Error watchdog expected done seen timeout");
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_ident();
      t_freeze();
      t_clean();
      t_weak();
      t_tenth();
      t_dead();
      close_out();
   end
endmodule

`default_nettype wire
